// ==== src/sink_driver_pkg.sv ====
// Purpose: Shared constants and carriers for the latched sink driver.
// Assumes: Host pins are already synchronous to sys_clk.
// Notes:   Every size and the shift, latch, sink and serial reset values live here.
package sink_driver_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int unsigned STAGE_COUNT = 8;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned FIFO_WIDTH  = 1;

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam logic [STAGE_COUNT-1:0] SHIFT_RESET = 8'h00;
  localparam logic [STAGE_COUNT-1:0] LATCH_RESET = 8'h00;
  localparam logic [STAGE_COUNT-1:0] SINK_OFF    = 8'h00;
  localparam logic                   SERIAL_RESET = 1'h0;

  // ************************************************************
  // Pin carrier from the host controller
  // ************************************************************
  typedef struct packed {
    logic shiftClk;
    logic serialIn;
    logic latch_strobe;
    logic outDisable;
  } hostPins_s;

endpackage

// ==== src/bit_fifo.sv ====
// Purpose: Small FIFO with a registered read stage.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Holds DEPTH words in the array plus one in the read stage.
`timescale 1ns/1ps
module bit_fifo #(
  parameter int unsigned WIDTH = sink_driver_pkg::FIFO_WIDTH,
  parameter int unsigned DEPTH = sink_driver_pkg::FIFO_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : gBad
    $error("bit_fifo needs WIDTH >= 1 and DEPTH a power of two >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 count;
    logic                        outValid;
    logic [WIDTH-1:0]            outData;
    logic                        inReady;
  } fifoState_s;

  // Ready is high straight out of reset
  localparam fifoState_s RESET_STATE = '{
    mem: '0, wrPtr: '0, rdPtr: '0, count: '0,
    outValid: 1'b0, outData: '0, inReady: 1'b1};

  fifoState_s stQ;
  fifoState_s stD;
  logic       push;
  logic       take;
  logic       load;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    stD  = stQ;
    push = inValid & stQ.inReady;
    take = stQ.outValid & outReady;
    load = (stQ.count != '0) & (~stQ.outValid | take);
    if (push) begin
      stD.mem[stQ.wrPtr] = inData;
      stD.wrPtr          = stQ.wrPtr + AW'(1);
    end
    if (load) begin
      stD.outData  = stQ.mem[stQ.rdPtr];
      stD.outValid = 1'b1;
      stD.rdPtr    = stQ.rdPtr + AW'(1);
    end else if (take) begin
      stD.outValid = 1'b0;
    end
    if (push && !load) begin
      stD.count = stQ.count + (AW+1)'(1);
    end else if (load && !push) begin
      stD.count = stQ.count - (AW+1)'(1);
    end
    // Registered ready keeps the pin path free of logic
    stD.inReady = (stD.count < (AW+1)'(DEPTH));
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stQ <= RESET_STATE;
    end else begin
      stQ <= stD;
    end
  end

  assign inReady  = stQ.inReady;
  assign outValid = stQ.outValid;
  assign outData  = stQ.outData;

endmodule

// ==== src/serial_sink_driver.sv ====
// Purpose: Serial-in, latched, gated eight-way sink driver.
// Assumes: Host pins are synchronous to sys_clk (10 MHz).
// Notes:   Shift clock edges queue bits in a FIFO before the register.
`timescale 1ns/1ps
module serial_sink_driver #(
  parameter int unsigned STAGES = sink_driver_pkg::STAGE_COUNT,
  parameter int unsigned DEPTH  = sink_driver_pkg::FIFO_DEPTH
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  sink_driver_pkg::hostPins_s     hostPins,
  input  wire logic                      shiftHold,
  output logic                           serialOut,
  output logic [STAGES-1:0]              sinkOn,
  output logic                           shiftReady
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (STAGES != sink_driver_pkg::STAGE_COUNT) begin : gBadStages
    $error("serial_sink_driver supports exactly eight stages");
  end

  typedef struct packed {
    logic [STAGES-1:0] shiftReg;
    logic [STAGES-1:0] latches;
    logic [STAGES-1:0] sinks;
    logic              serial;
    logic              clkPrev;
  } drvState_s;

  localparam drvState_s RESET_STATE = '{
    shiftReg: sink_driver_pkg::SHIFT_RESET,
    latches:  sink_driver_pkg::LATCH_RESET,
    sinks:    sink_driver_pkg::SINK_OFF,
    serial:   sink_driver_pkg::SERIAL_RESET,
    clkPrev:  1'b0};

  drvState_s stQ;
  drvState_s stD;
  logic      edgeSeen;
  logic      bitValid;
  logic      bitData;
  logic      pop;

  // ************************************************************
  // Edge queue
  // ************************************************************
  // Edges taken while the queue is full are lost; the host watches
  // shiftReady and pauses its shift clock instead.
  assign edgeSeen = hostPins.shiftClk & ~stQ.clkPrev;

  bit_fifo #(
    .WIDTH (1),
    .DEPTH (DEPTH)
  ) uQueue (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .inValid  (edgeSeen),
    .inData   (hostPins.serialIn),
    .inReady  (shiftReady),
    .outValid (bitValid),
    .outData  (bitData),
    .outReady (~shiftHold)
  );

  assign pop = bitValid & ~shiftHold;

  // ************************************************************
  // Shift, latch and output gating
  // ************************************************************
  always_comb begin
    stD         = stQ;
    stD.clkPrev = hostPins.shiftClk;
    if (pop) begin
      stD.shiftReg = {stQ.shiftReg[STAGES-2:0], bitData};
    end
    stD.serial = stD.shiftReg[STAGES-1];
    if (hostPins.latch_strobe) begin
      stD.latches = stD.shiftReg;
    end
    if (hostPins.outDisable) begin
      stD.sinks = sink_driver_pkg::SINK_OFF;
    end else begin
      stD.sinks = stD.latches;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stQ <= RESET_STATE;
    end else begin
      stQ <= stD;
    end
  end

  assign serialOut = stQ.serial;
  assign sinkOn    = stQ.sinks;

  // ************************************************************
  // Assertions
  // ************************************************************
  AST_LOAD_FIRST: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    pop |=> stQ.shiftReg[0] == $past(bitData))
    else $error("first stage did not take the queued bit");

  AST_SHIFT_ON: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    pop |=> stQ.shiftReg[STAGES-1:1] == $past(stQ.shiftReg[STAGES-2:0]))
    else $error("stages did not move on by one");

  AST_SERIAL_TAP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    serialOut == stQ.shiftReg[STAGES-1])
    else $error("serial output differs from last stage");

  AST_LATCH_FOLLOW: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    hostPins.latch_strobe |=> stQ.latches == stQ.shiftReg)
    else $error("latches did not copy the shift register");

  AST_LATCH_HOLD: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !hostPins.latch_strobe |=> $stable(stQ.latches))
    else $error("latches changed with strobe low");

  AST_SINKS_OFF: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    hostPins.outDisable |=> sinkOn == sink_driver_pkg::SINK_OFF)
    else $error("a sink stayed on while disabled");

  AST_DISABLE_NO_EFFECT: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $changed(hostPins.outDisable) && !pop && !hostPins.latch_strobe
    |=> $stable(stQ.shiftReg) && $stable(stQ.latches))
    else $error("output disable altered stored data");

  AST_SINK_FOLLOW: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !hostPins.outDisable |=> sinkOn == stQ.latches)
    else $error("sinks do not match latches while enabled");

  AST_RESET_CLEAR: assert property (
    @(posedge sys_clk)
    !rst_n |=> stQ.shiftReg == sink_driver_pkg::SHIFT_RESET
           && stQ.latches == sink_driver_pkg::LATCH_RESET
           && sinkOn == sink_driver_pkg::SINK_OFF && !serialOut)
    else $error("reset left a stage or latch set");

  AST_NO_EDGE_HOLD: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !pop |=> $stable(stQ.shiftReg) && $stable(serialOut))
    else $error("register moved without a shift edge");

  AST_EDGE_REACHES: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
  // A pushed bit is popped two edges later once the drain runs free
    edgeSeen && shiftReady ##1 (!shiftHold) [*2] |-> pop)
    else $error("queued edge never reached the register");

  AST_SERIAL_MOVES: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    pop |=> serialOut == $past(stQ.shiftReg[STAGES-2]))
    else $error("serial output did not take stage seven");

  AST_LATCH_SEES_SHIFT: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    hostPins.latch_strobe && pop |=> stQ.latches[0] == $past(bitData))
    else $error("open latch missed the bit shifted in");

  AST_DISABLED_STILL_LATCHES: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    hostPins.outDisable && hostPins.latch_strobe
    |=> stQ.latches == stQ.shiftReg && sinkOn == sink_driver_pkg::SINK_OFF)
    else $error("disabled outputs stopped the latches");

  // ************************************************************
  // Cover points
  // ************************************************************
  COV_EIGHT_SHIFTS: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    pop [*8]);

  COV_STROBE_AFTER_SHIFT: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    pop ##1 !pop ##1 hostPins.latch_strobe);

  COV_QUEUE_FULL: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    !shiftReady);

  COV_ENABLE_TOGGLE: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    hostPins.outDisable ##1 !hostPins.outDisable ##1 (sinkOn != '0));

  COV_EDGE_DROPPED: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    edgeSeen && !shiftReady);

endmodule

// ==== bench/host_model.sv ====
// Purpose: Host controller driving shift clock, data, strobe, disable.
// Assumes: Calls are made just after a falling edge of sys_clk.
// Notes:   Data shows the inverse level once its hold time has passed.
`timescale 1ns/1ps
module host_model (
  input  wire logic                  sys_clk,
  input  wire logic                  shiftReady,
  output sink_driver_pkg::hostPins_s hostPins,
  output logic                       timedOut
);
  initial begin
    hostPins = '0;
    timedOut = 1'b0;
  end

  task automatic set_ctl(input logic strobe, input logic dis);
    @(negedge sys_clk);
    hostPins.latch_strobe = strobe;
    hostPins.outDisable   = dis;
  endtask

  // Top bit goes first, so with n=8 it ends in stage 8; obey=0 ignores ready
  task automatic send_bits(input logic [31:0] bits, input int n,
                           input logic obey);
    int k;
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge sys_clk);
      if (hostPins.latch_strobe) hostPins.outDisable = 1'b1;
      for (k = 0; k < 64 && obey && !shiftReady; k++) @(negedge sys_clk);
      if (k == 64) timedOut = 1'b1;
      hostPins.shiftClk = 1'b1;
      hostPins.serialIn = bits[i];
      @(negedge sys_clk);
      hostPins.shiftClk = 1'b0;
      hostPins.serialIn = ~bits[i];
    end
  endtask

  task automatic wiggle(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      hostPins.serialIn = ~hostPins.serialIn;
    end
  endtask
endmodule

// ==== bench/tb.sv ====
// Purpose: Self-checking bench for the latched sink driver.
// Assumes: Inputs change at the falling edge, outputs read there too.
// Notes:   Queue capacity taken as 16 words plus the read stage.
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [7:0] data;
    logic       dis;
    logic [7:0] expSink;
    logic       expSer;
  } row_s;

  logic                       sys_clk   = 1'b0;
  logic                       rst_n     = 1'b0;
  logic                       shiftHold = 1'b0;
  sink_driver_pkg::hostPins_s hostPins;
  logic                       serialOut;
  logic [7:0]                 sinkOn;
  logic                       shiftReady;
  logic                       timedOut;
  int                         num_errors = 0;
  int                         cmp_count  = 0;
  row_s                       rows [4] = '{'{8'ha5, 1'b0, 8'ha5, 1'b1},
    '{8'h3c, 1'b1, 8'h00, 1'b0}, '{8'hff, 1'b0, 8'hff, 1'b1},
    '{8'h01, 1'b0, 8'h01, 1'b0}};

  always #50 sys_clk = ~sys_clk;

  serial_sink_driver serial_sink_driver_i (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .hostPins   (hostPins),
    .shiftHold  (shiftHold),
    .serialOut  (serialOut),
    .sinkOn     (sinkOn),
    .shiftReady (shiftReady)
  );

  host_model host_model_i (
    .sys_clk    (sys_clk),
    .shiftReady (shiftReady),
    .hostPins   (hostPins),
    .timedOut   (timedOut)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic chk_sink(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: sinkOn %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string s);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s is %b, expected %b", $time, s, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    idle(10);
    rst_n = 1'b1;
    chk_sink(sinkOn, 8'h00);
    chk_bit(serialOut, 1'b0, "serialOut");
    $display("test reset done");
    foreach (rows[i]) begin
      host_model_i.send_bits({24'h0, rows[i].data}, 8, 1'b1);
      idle(6);
      host_model_i.set_ctl(1'b1, rows[i].dis);
      host_model_i.set_ctl(1'b0, rows[i].dis);
      idle(2);
      chk_sink(sinkOn, rows[i].expSink);
      chk_bit(serialOut, rows[i].expSer, "serialOut");
    end
    $display("test rows done");
    host_model_i.send_bits(32'h0f, 8, 1'b1);
    idle(6);
    chk_sink(sinkOn, 8'h01);
    chk_bit(serialOut, 1'b0, "serialOut");
    host_model_i.set_ctl(1'b0, 1'b1);
    idle(1);
    chk_sink(sinkOn, 8'h00);
    host_model_i.set_ctl(1'b0, 1'b0);
    idle(1);
    chk_sink(sinkOn, 8'h01);
    host_model_i.set_ctl(1'b1, 1'b0);
    idle(1);
    chk_sink(sinkOn, 8'h0f);
    $display("test hold and disable done");
    host_model_i.send_bits(32'ha, 4, 1'b1);
    idle(6);
    chk_sink(sinkOn, 8'h00);
    host_model_i.set_ctl(1'b1, 1'b0);
    idle(1);
    chk_sink(sinkOn, 8'hfa);
    host_model_i.wiggle(10);
    chk_sink(sinkOn, 8'hfa);
    chk_bit(serialOut, 1'b1, "serialOut");
    $display("test transparent done");
    shiftHold = 1'b1;
    // Ten zeros and a pattern fill all 17 places; three ones are dropped
    host_model_i.send_bits(32'h2d7, 20, 1'b0);
    chk_bit(shiftReady, 1'b0, "shiftReady");
    chk_sink(sinkOn, 8'h00);
    shiftHold = 1'b0;
    idle(40);
    host_model_i.set_ctl(1'b1, 1'b0);
    idle(1);
    chk_sink(sinkOn, 8'h5a);
    chk_bit(shiftReady, 1'b1, "shiftReady");
    $display("test queue full done");
    rst_n = 1'b0;
    idle(2);
    rst_n = 1'b1;
    chk_sink(sinkOn, 8'h00);
    chk_bit(serialOut, 1'b0, "serialOut");
    chk_bit(timedOut, 1'b0, "timedOut");
    $display("test second reset done");
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    $display("Error at %0t: run did not finish", $time);
    tally_and_finish();
  end
endmodule
